// ===== rssc_backplane_model.sv
// Purpose: Transmit bus timebase of the backplane
// Assumes: One bus bit per clock, frame length set by the bench
// Notes:   lastPos is the position that the block sampled last
`default_nettype none
module rssc_backplane_model
(
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic [10:0] frameBits,
  output logic             txFrameStart,
  output logic             txBitTick,
  output logic [10:0]      lastPos
);
  timeunit 1ns;
  timeprecision 1ns;
  // ---------------------------------------------------------------
  // Frame counter
  // ---------------------------------------------------------------
  logic [10:0] posQ;
  always_ff @(posedge clock)
  begin
    lastPos <= posQ;
    if (rst || posQ >= frameBits - 11'h001)
    begin
      posQ         <= rst ? frameBits - 11'h001 : 11'h000;
      txFrameStart <= !rst;
      txBitTick    <= 1'b0;
    end
    else
    begin
      posQ         <= posQ + 11'h001;
      txFrameStart <= 1'b0;
      txBitTick    <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// ===== rssc_pkg.sv
// Purpose: Shared constants and carriers for the sync and signaling configuration block
// Assumes: AXI4-Lite with 32-bit data, one clock at 50 MHz
// Notes:   Register byte address is four times the register index
`default_nettype none
package rssc_pkg;
  // ---------------------------------------------------------------
  // Register indices and byte addresses
  // ---------------------------------------------------------------
  localparam logic [9:0]  IDX_TX_SLOT   = 10'h0D6;
  localparam logic [9:0]  IDX_RX_SIGCFG = 10'h0D7;
  localparam logic [9:0]  IDX_RX_FRMOFF = 10'h0D8;
  localparam logic [11:0] ADDR_TX_SLOT   = {IDX_TX_SLOT, 2'b00};
  localparam logic [11:0] ADDR_RX_SIGCFG = {IDX_RX_SIGCFG, 2'b00};
  localparam logic [11:0] ADDR_RX_FRMOFF = {IDX_RX_FRMOFF, 2'b00};
  localparam logic [11:0] ADDR_CTRL      = 12'h000;
  localparam logic [11:0] ADDR_STACK_EN  = 12'h004;
  localparam logic [11:0] ADDR_INSERT_EN = 12'h008;
  localparam logic [11:0] ADDR_STATUS    = 12'h00C;
  // ---------------------------------------------------------------
  // Field positions of the signaling configuration register
  // ---------------------------------------------------------------
  localparam int SIG_TRANSPARENT = 0;
  localparam int SIG_FRZ_ASSERT  = 1;
  localparam int SIG_FRZ_RELEASE = 2;
  localparam int SIG_DEBOUNCE    = 3;
  localparam int SIG_PATTERN     = 4;
  localparam int SIG_OVERWRITE   = 5;
  localparam int SIG_PERIODIC    = 6;
  // ---------------------------------------------------------------
  // Field positions of the control register
  // ---------------------------------------------------------------
  localparam int CTRL_T1     = 0;
  localparam int CTRL_CAS    = 1;
  localparam int CTRL_IDLE   = 2;
  localparam int CTRL_RATE   = 4;
  localparam int CTRL_SYNCBIT = 8;
  // ---------------------------------------------------------------
  // Reset values, bus rates and fixed values
  // ---------------------------------------------------------------
  localparam logic [6:0]  RST_TX_SLOT  = 7'h00;
  localparam logic [6:0]  RST_SIGCFG   = 7'h00;
  localparam logic [4:0]  RST_FRMOFF   = 5'h00;
  localparam logic [2:0]  RATE_1536    = 3'h0;
  localparam logic [2:0]  RATE_1544    = 3'h1;
  localparam logic [2:0]  RATE_2048    = 3'h2;
  localparam logic [2:0]  RATE_4096    = 3'h3;
  localparam logic [2:0]  RATE_8192    = 3'h4;
  localparam logic [3:0]  FREEZE_PATTERN = 4'hF;
  localparam logic [4:0]  MF_LEN_T1    = 5'h18;
  localparam logic [4:0]  MF_LEN_E1    = 5'h10;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

  typedef struct packed {
    logic        awvalid;
    logic [11:0] awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [11:0] araddr;
    logic        rready;
  } rssc_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } rssc_axi_rsp_t;

  typedef struct packed {
    logic       valid;
    logic [4:0] channel;
    logic [3:0] abcd;
  } rssc_sig_t;

  // Bits per frame on the transmit bus for each rate
  function automatic logic [10:0] rssc_frame_bits(input logic [2:0] rate);
    logic [10:0] n;
    n = 11'h0C0;
    unique case (rate)
      RATE_1544: n = 11'h0C1;
      RATE_2048: n = 11'h100;
      RATE_4096: n = 11'h200;
      RATE_8192: n = 11'h400;
      default:   n = 11'h0C0;
    endcase
    return n;
  endfunction
endpackage
`default_nettype wire

// ===== rssc_top.sv
// Purpose: Sync placement and receive signaling update configuration for one framer
// Assumes: Timebase strobes and signaling inputs are synchronous to clock
// Notes:   Registers reached over AXI4-Lite; all outputs registered
`default_nettype none
module rssc_top
  import rssc_pkg::*;
(
  input  wire logic          clock,
  input  wire logic          rst,
  input  wire rssc_axi_req_t axiReq,
  output var  rssc_axi_rsp_t axiRsp,
  input  wire logic          txBitTick,
  input  wire logic          txFrameStart,
  output var  logic          txFrameSyncOut,
  output var  logic          txMultiframeSyncOut,
  input  wire logic          rxFrameStart,
  input  wire logic          rxMultiframeAlign,
  input  wire logic [4:0]    rxSlipFrameOffset,
  input  wire logic [4:0]    rxChannel,
  output var  logic          rxMultiframeSyncOut,
  output var  logic          rxReinsertActive,
  input  wire logic          rxSlotValid,
  input  wire logic [7:0]    rxSlotData,
  output var  logic          rxSlipWriteValid,
  output var  logic [7:0]    rxSlipWriteData,
  input  wire rssc_sig_t     rxSignaling,
  input  wire logic          rxMultiframeEnd,
  input  wire logic          freezeCondition,
  output var  logic          signalingFreeze,
  output var  rssc_sig_t     stackPush,
  output var  logic          signalingIrq
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    rssc_axi_rsp_t   rsp;
    logic            awHeld;
    logic [11:0]     awAddr;
    logic            wHeld;
    logic [31:0]     wData;
    logic [3:0]      wStrb;
    logic [6:0]      txSlot;
    logic [6:0]      sigCfg;
    logic [4:0]      frmOff;
    logic [10:0]     ctrl;
    logic [31:0]     stackEn;
    logic [31:0]     insertEn;
    logic [9:0]      txOffAct;
    logic [2:0]      txRateAct;
    logic [10:0]     txPos;
    logic [4:0]      txFrame;
    logic [4:0]      rxSyncAct;
    logic [4:0]      rxFrame;
    logic [31:0][3:0] inBuf;
    logic [31:0][3:0] outBuf;
    logic            txFs;
    logic            txMs;
    logic            rxMs;
    logic            reinsert;
    logic            slipValid;
    logic [7:0]      slipData;
    logic            frzPin;
    rssc_sig_t       push;
    logic            irq;
  } rssc_state_t;

  rssc_state_t s_q;
  rssc_state_t s_d;

  logic        t1Mode;
  logic        casOn;
  logic [2:0]  rate;
  logic [4:0]  mfLen;
  logic [10:0] frameBits;
  logic        blockAll;
  logic        patHit;
  logic [3:0]  inc;
  logic [3:0]  oldIn;
  logic [3:0]  oldOut;
  logic [3:0]  newOut;
  logic [4:0]  ch;
  logic        doWrite;
  logic [4:0]  rel;
  logic [4:0]  nxtFrame;
  logic [31:0] rdVal;
  logic        rdHit;
  logic        wrHit;
  logic [4:0]  alignFrame;

  assign t1Mode    = s_q.ctrl[CTRL_T1];
  assign casOn     = s_q.ctrl[CTRL_CAS];
  assign rate      = s_q.ctrl[CTRL_RATE +: 3];
  assign mfLen     = t1Mode ? MF_LEN_T1 : MF_LEN_E1;
  always_comb
  begin
    s_d = s_q;
    ch = rxSignaling.channel;
    inc = rxSignaling.abcd;
    oldIn = s_q.inBuf[ch];
    oldOut = s_q.outBuf[ch];
    newOut = oldOut;
    doWrite = 1'b0;
    rdVal = 32'h0000_0000;
    rdHit = 1'b1;
    wrHit = 1'b1;
    rel = 5'h00;
    nxtFrame = s_q.rxFrame;
    alignFrame = 5'h00;

    // ---------------------------------------------------------------
    // AXI4-Lite write channel
    // ---------------------------------------------------------------
    if (axiReq.awvalid && s_q.rsp.awready)
    begin
      s_d.awHeld = 1'b1;
      s_d.awAddr = axiReq.awaddr;
    end
    if (axiReq.wvalid && s_q.rsp.wready)
    begin
      s_d.wHeld = 1'b1;
      s_d.wData = axiReq.wdata;
      s_d.wStrb = axiReq.wstrb;
    end
    if (s_q.rsp.bvalid && axiReq.bready)
    begin
      s_d.rsp.bvalid = 1'b0;
    end
    if (s_q.awHeld && s_q.wHeld && !s_q.rsp.bvalid)
    begin
      s_d.awHeld = 1'b0;
      s_d.wHeld = 1'b0;
      s_d.rsp.bvalid = 1'b1;
      unique case ({s_q.awAddr[11:2], 2'b00})
        ADDR_TX_SLOT:
          if (s_q.wStrb[0])
          begin
            s_d.txSlot = s_q.wData[6:0];
          end
        ADDR_RX_SIGCFG:
          if (s_q.wStrb[0])
          begin
            s_d.sigCfg = s_q.wData[6:0];
          end
        ADDR_RX_FRMOFF:
          if (s_q.wStrb[0])
          begin
            s_d.frmOff = s_q.wData[4:0];
          end
        ADDR_CTRL:
        begin
          if (s_q.wStrb[0])
          begin
            s_d.ctrl[7:0] = s_q.wData[7:0];
          end
          if (s_q.wStrb[1])
          begin
            s_d.ctrl[10:8] = s_q.wData[10:8];
          end
        end
        ADDR_STACK_EN:
          for (int b = 0; b < 4; b++)
            if (s_q.wStrb[b])
              s_d.stackEn[b*8 +: 8] = s_q.wData[b*8 +: 8];
        ADDR_INSERT_EN:
          for (int b = 0; b < 4; b++)
            if (s_q.wStrb[b])
              s_d.insertEn[b*8 +: 8] = s_q.wData[b*8 +: 8];
        default:
          wrHit = 1'b0;
      endcase
      s_d.rsp.bresp = wrHit ? RESP_OKAY : RESP_SLVERR;
    end
    s_d.rsp.awready = !s_d.awHeld;
    s_d.rsp.wready = !s_d.wHeld;

    // ---------------------------------------------------------------
    // AXI4-Lite read channel
    // ---------------------------------------------------------------
    if (s_q.rsp.rvalid && axiReq.rready)
    begin
      s_d.rsp.rvalid = 1'b0;
    end
    if (axiReq.arvalid && s_q.rsp.arready)
    begin
      unique case ({axiReq.araddr[11:2], 2'b00})
        ADDR_TX_SLOT:   rdVal = {25'h0, s_q.txSlot};
        ADDR_RX_SIGCFG: rdVal = {25'h0, s_q.sigCfg};
        ADDR_RX_FRMOFF: rdVal = {27'h0, s_q.frmOff};
        ADDR_CTRL:      rdVal = {21'h0, s_q.ctrl};
        ADDR_STACK_EN:  rdVal = s_q.stackEn;
        ADDR_INSERT_EN: rdVal = s_q.insertEn;
        ADDR_STATUS:    rdVal = {19'h0, s_q.rxFrame, s_q.txFrame, 2'h0, s_q.frzPin};
        default:        rdHit = 1'b0;
      endcase
      s_d.rsp.rvalid = 1'b1;
      s_d.rsp.rdata = rdVal;
      s_d.rsp.rresp = rdHit ? RESP_OKAY : RESP_SLVERR;
    end
    s_d.rsp.arready = !s_d.rsp.rvalid;

    // ---------------------------------------------------------------
    // Transmit bus sync placement
    // ---------------------------------------------------------------
    s_d.txFs = 1'b0;
    s_d.txMs = 1'b0;
    if (txFrameStart)
    begin
      s_d.txPos = 11'h000;
      s_d.txOffAct = {s_q.txSlot, s_q.ctrl[CTRL_SYNCBIT +: 3]};
      s_d.txRateAct = rate;
      s_d.txFrame = (s_q.txFrame + 5'h01 >= mfLen) ? 5'h00 : s_q.txFrame + 5'h01;
    end
    else if (txBitTick)
    begin
      s_d.txPos = s_q.txPos + 11'h001;
    end
    // Position counts {slot, bit}; frame start is bit 0 of the new frame
    frameBits = rssc_frame_bits(s_d.txRateAct);
    if ((txFrameStart || txBitTick) && s_d.txPos == {1'b0, s_d.txOffAct})
    begin
      if ({1'b0, s_d.txOffAct} < frameBits)
      begin
        s_d.txFs = 1'b1;
        s_d.txMs = (s_d.txFrame == 5'h00);
      end
    end

    // ---------------------------------------------------------------
    // Receive multiframe sync and reinsertion frames
    // ---------------------------------------------------------------
    s_d.rxMs = 1'b0;
    if (rxFrameStart)
    begin
      if (t1Mode)
      begin
        s_d.rxSyncAct = (s_q.frmOff > 5'h17) ? 5'h01 : s_q.frmOff + 5'h01;
      end
      else
      begin
        s_d.rxSyncAct = {1'b0, s_q.frmOff[3:0]};
      end
      nxtFrame = (s_q.rxFrame + 5'h01 >= mfLen + (t1Mode ? 5'h01 : 5'h00))
               ? (t1Mode ? 5'h01 : 5'h00) : s_q.rxFrame + 5'h01;
      if (s_q.sigCfg[SIG_TRANSPARENT] && rxMultiframeAlign)
      begin
        alignFrame = s_q.rxSyncAct + rxSlipFrameOffset;
        nxtFrame = (alignFrame >= mfLen + (t1Mode ? 5'h01 : 5'h00))
                 ? alignFrame - mfLen : alignFrame;
      end
      s_d.rxFrame = nxtFrame;
      s_d.rxMs = (nxtFrame == s_d.rxSyncAct);
    end
    rel = (s_q.rxFrame >= s_q.rxSyncAct) ? s_q.rxFrame - s_q.rxSyncAct
        : s_q.rxFrame + mfLen - s_q.rxSyncAct;
    s_d.reinsert = s_q.insertEn[rxChannel] && (t1Mode
                 ? (rel == 5'h05 || rel == 5'h0B || rel == 5'h11 || rel == 5'h17)
                 : (rel == 5'h00));

    // ---------------------------------------------------------------
    // Robbed-bit overwrite before the slip buffer
    // ---------------------------------------------------------------
    s_d.slipValid = rxSlotValid;
    s_d.slipData = rxSlotData;
    if (rxSlotValid && t1Mode && s_q.sigCfg[SIG_OVERWRITE] && !s_q.ctrl[CTRL_IDLE]
        && (rel == 5'h05 || rel == 5'h0B || rel == 5'h11 || rel == 5'h17))
    begin
      s_d.slipData[0] = 1'b1;
    end

    // ---------------------------------------------------------------
    // Signaling buffer and stack updates
    // ---------------------------------------------------------------
    blockAll = !s_q.sigCfg[SIG_FRZ_RELEASE]
             && (s_q.sigCfg[SIG_FRZ_ASSERT] || freezeCondition);
    s_d.frzPin = blockAll;
    patHit = t1Mode && s_q.sigCfg[SIG_PATTERN] && (inc == FREEZE_PATTERN);
    s_d.push = '0;
    if (rxSignaling.valid && !blockAll && !patHit)
    begin
      s_d.inBuf[ch] = inc;
      if (s_q.sigCfg[SIG_DEBOUNCE] && s_q.stackEn[ch])
      begin
        for (int b = 0; b < 4; b++)
          newOut[b] = (inc[b] == oldIn[b]) ? inc[b] : oldOut[b];
        doWrite = (newOut != oldOut);
        if (doWrite)
        begin
          s_d.outBuf[ch] = newOut;
        end
      end
      else
      begin
        newOut = inc;
        s_d.outBuf[ch] = inc;
        doWrite = (inc != oldOut);
      end
      if (doWrite && s_q.stackEn[ch])
      begin
        s_d.push.valid = 1'b1;
        s_d.push.channel = ch;
        s_d.push.abcd = newOut;
      end
    end
    if (rxMultiframeEnd && s_q.sigCfg[SIG_DEBOUNCE] && !blockAll)
    begin
      for (int c = 0; c < 32; c++)
        if (s_q.stackEn[c] && !(rxSignaling.valid && ch == 5'(c)))
          s_d.outBuf[c] = s_q.inBuf[c];
    end

    // ---------------------------------------------------------------
    // Signaling interrupt source
    // ---------------------------------------------------------------
    if (s_q.sigCfg[SIG_PERIODIC] && !t1Mode && casOn)
    begin
      s_d.irq = rxMultiframeEnd;
    end
    else
    begin
      s_d.irq = s_d.push.valid;
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      s_q <= '0;
      s_q.rsp.awready <= 1'b1;
      s_q.rsp.wready <= 1'b1;
      s_q.rsp.arready <= 1'b1;
      s_q.txSlot <= RST_TX_SLOT;
      s_q.sigCfg <= RST_SIGCFG;
      s_q.frmOff <= RST_FRMOFF;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign axiRsp              = s_q.rsp;
  assign txFrameSyncOut      = s_q.txFs;
  assign txMultiframeSyncOut = s_q.txMs;
  assign rxMultiframeSyncOut = s_q.rxMs;
  assign rxReinsertActive    = s_q.reinsert;
  assign rxSlipWriteValid    = s_q.slipValid;
  assign rxSlipWriteData     = s_q.slipData;
  assign signalingFreeze     = s_q.frzPin;
  assign stackPush           = s_q.push;
  assign signalingIrq        = s_q.irq;
endmodule
`default_nettype wire

// ===== rssc_top_sva.sv
// Purpose: Port assertions for rssc_top
// Assumes: One clock, rst synchronous and active high
// Notes:   Bound to every rssc_top instance
`default_nettype none
module rssc_top_sva
  import rssc_pkg::*;
(
  input wire logic          clock,
  input wire logic          rst,
  input wire rssc_axi_req_t axiReq,
  input wire rssc_axi_rsp_t axiRsp,
  input wire logic          txBitTick,
  input wire logic          txFrameStart,
  input wire logic          txFrameSyncOut,
  input wire logic          txMultiframeSyncOut,
  input wire logic          rxFrameStart,
  input wire logic          rxMultiframeSyncOut,
  input wire logic          rxSlotValid,
  input wire logic [7:0]    rxSlotData,
  input wire logic          rxSlipWriteValid,
  input wire logic [7:0]    rxSlipWriteData,
  input wire rssc_sig_t     rxSignaling,
  input wire logic          rxMultiframeEnd,
  input wire logic          signalingFreeze,
  input wire rssc_sig_t     stackPush
);
  timeunit 1ns;
  timeprecision 1ns;
  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  sequence sWrWait;
    axiRsp.bvalid && !axiReq.bready;
  endsequence
  sequence sRdWait;
    axiRsp.rvalid && !axiReq.rready;
  endsequence
  a_bresp_hold: assert property (sWrWait |=> axiRsp.bvalid && $stable(axiRsp.bresp))
    else $error("write response dropped");
  a_rdata_hold: assert property (sRdWait |=> axiRsp.rvalid && $stable(axiRsp.rdata))
    else $error("read data dropped");
  a_read_answer: assert property (axiReq.arvalid && axiRsp.arready |=> axiRsp.rvalid)
    else $error("read answer late");
  a_slip_copy: assert property (rxSlotValid |=> rxSlipWriteValid
    && rxSlipWriteData[7:1] == $past(rxSlotData[7:1])) else $error("slot copy wrong");
  a_slip_cause: assert property (rxSlipWriteValid |-> $past(rxSlotValid))
    else $error("slot write without slot");
  a_tx_cause: assert property (txFrameSyncOut |-> $past(txBitTick || txFrameStart))
    else $error("frame sync without strobe");
  a_mf_in_frame: assert property (txMultiframeSyncOut |-> txFrameSyncOut)
    else $error("multiframe sync alone");
  a_sync_single: assert property (txFrameSyncOut |=> !txFrameSyncOut)
    else $error("frame sync too long");
  a_rxmf_cause: assert property (rxMultiframeSyncOut |-> $past(rxFrameStart))
    else $error("rx sync without frame");
  a_frozen_quiet: assert property (signalingFreeze && $past(signalingFreeze)
    |-> !stackPush.valid) else $error("push while frozen");
  a_push_cause: assert property (stackPush.valid
    |-> $past(rxSignaling.valid)) else $error("push without cause");
endmodule
bind rssc_top rssc_top_sva chk (
  .clock(clock), .rst(rst), .axiReq(axiReq), .axiRsp(axiRsp),
  .txBitTick(txBitTick), .txFrameStart(txFrameStart), .txFrameSyncOut(txFrameSyncOut),
  .txMultiframeSyncOut(txMultiframeSyncOut), .rxFrameStart(rxFrameStart),
  .rxMultiframeSyncOut(rxMultiframeSyncOut), .rxSlotValid(rxSlotValid),
  .rxSlotData(rxSlotData), .rxSlipWriteValid(rxSlipWriteValid),
  .rxSlipWriteData(rxSlipWriteData), .rxSignaling(rxSignaling),
  .rxMultiframeEnd(rxMultiframeEnd), .signalingFreeze(signalingFreeze),
  .stackPush(stackPush)
);
`default_nettype wire

// ===== tb.sv
// Purpose: Self-checking bench for rssc_top
// Assumes: 50 MHz clock, synchronous reset held 16 cycles
// Notes:   Transmit timebase comes from the backplane model
`default_nettype none
module tb
  import rssc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic          clock = 1'b0;
  logic          rst = 1'b1;
  rssc_axi_req_t axiReq = '0;
  rssc_axi_rsp_t axiRsp;
  logic          txBitTick, txFrameStart, txFsync, txMfsync;
  logic          rxFrameStart = 1'b0, rxMfSync, rxReinsert, rxMfAlign = 1'b0;
  logic [4:0]    rxChannel = 5'h03, rxSlipOff = 5'h00;
  logic          rxSlotValid = 1'b0, slipValid, rxMfEnd = 1'b0;
  logic [7:0]    slipData, slotData = 8'h00;
  rssc_sig_t     rxSignaling = '0, stackPush;
  logic          freezeCond = 1'b0, sigFreeze, sigIrq;
  logic [10:0]   frameBits = 11'h100, lastPos;
  int            errCount = 0, numChecks = 0;
  always #10 clock = ~clock;
  rssc_top dut (
    .clock(clock), .rst(rst), .axiReq(axiReq), .axiRsp(axiRsp), .txBitTick(txBitTick),
    .txFrameStart(txFrameStart), .txFrameSyncOut(txFsync), .txMultiframeSyncOut(txMfsync),
    .rxFrameStart(rxFrameStart), .rxMultiframeAlign(rxMfAlign), .rxSlipFrameOffset(rxSlipOff),
    .rxChannel(rxChannel), .rxMultiframeSyncOut(rxMfSync), .rxReinsertActive(rxReinsert),
    .rxSlotValid(rxSlotValid), .rxSlotData(slotData), .rxSlipWriteValid(slipValid),
    .rxSlipWriteData(slipData), .rxSignaling(rxSignaling), .rxMultiframeEnd(rxMfEnd),
    .freezeCondition(freezeCond), .signalingFreeze(sigFreeze), .stackPush(stackPush),
    .signalingIrq(sigIrq)
  );
  rssc_backplane_model bp (
    .clock(clock), .rst(rst), .frameBits(frameBits), .txFrameStart(txFrameStart),
    .txBitTick(txBitTick), .lastPos(lastPos)
  );
  // ---------------------------------------------------------------
  // Compare and bus tasks
  // ---------------------------------------------------------------
  task automatic chkBit(input logic got, input logic exp);
    numChecks++;
    if (got !== exp)
    begin
      errCount++;
      $display("[ERR] %0t bit got %b exp %b", $time, got, exp);
    end
  endtask
  task automatic chkWord(input logic [31:0] got, input logic [31:0] exp);
    numChecks++;
    if (got !== exp)
    begin
      errCount++;
      $display("[ERR] %0t word got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic axiWr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clock);
    axiReq.awvalid <= 1'b1;
    axiReq.awaddr  <= a;
    axiReq.wvalid  <= 1'b1;
    axiReq.wdata   <= d;
    axiReq.wstrb   <= 4'hF;
    axiReq.bready  <= 1'b1;
    do
    begin
      @(posedge clock);
      if (axiRsp.awready === 1'b1)
        axiReq.awvalid <= 1'b0;
      if (axiRsp.wready === 1'b1)
        axiReq.wvalid <= 1'b0;
    end
    while (axiRsp.bvalid !== 1'b1);
    r = axiRsp.bresp;
    axiReq.bready <= 1'b0;
  endtask
  task automatic axiRd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clock);
    axiReq.arvalid <= 1'b1;
    axiReq.araddr  <= a;
    axiReq.rready  <= 1'b1;
    do
    begin
      @(posedge clock);
      if (axiRsp.arready === 1'b1)
        axiReq.arvalid <= 1'b0;
    end
    while (axiRsp.rvalid !== 1'b1);
    d = axiRsp.rdata;
    r = axiRsp.rresp;
    axiReq.rready <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] e = RESP_OKAY);
    logic [1:0] r;
    axiWr(a, d, r);
    chkWord({30'h0, r}, {30'h0, e});
  endtask
  task automatic rdChk(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0]  r;
    axiRd(a, d, r);
    chkWord(d, e);
    chkWord({30'h0, r}, {30'h0, er});
  endtask
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic tRegs;
    logic [11:0] ra [3];
    logic [31:0] rm [3];
    ra = '{ADDR_TX_SLOT, ADDR_RX_SIGCFG, ADDR_RX_FRMOFF};
    rm = '{32'h0000007F, 32'h0000007F, 32'h0000001F};
    for (int i = 0; i < 3; i++)
    begin
      rdChk(ra[i], 32'h0, RESP_OKAY);
      wr(ra[i], rm[i]);
      rdChk(ra[i], rm[i], RESP_OKAY);
      wr(ra[i], 32'h0);
    end
    wr(12'h7F0, 32'h1, RESP_SLVERR);
    rdChk(12'h7F0, 32'h0, RESP_SLVERR);
  endtask
  task automatic txCase(input logic [2:0] rate, input logic [6:0] slot, input logic [2:0] bo,
                        input logic exp);
    logic        found;
    logic [10:0] pos;
    int          bits;
    bits = rate == RATE_1536 ? 192 : rate == RATE_1544 ? 193 : rate == RATE_2048 ? 256 :
           rate == RATE_4096 ? 512 : 1024;
    frameBits <= bits[10:0];
    wr(ADDR_CTRL, {21'h0, bo, 1'b0, rate, 4'h0});
    wr(ADDR_TX_SLOT, {25'h0, slot});
    repeat (2 * bits + 4) @(posedge clock);
    found = 1'b0;
    pos = 11'h000;
    repeat (bits + 2)
    begin
      @(negedge clock);
      if (txFsync === 1'b1)
      begin
        found = 1'b1;
        pos = lastPos;
      end
    end
    chkBit(found, exp);
    if (exp)
      chkWord({21'h0, pos}, {22'h0, slot, bo});
  endtask
  task automatic tMf;
    int m = 0;
    repeat (4096) @(negedge clock) m += (txMfsync === 1'b1);
    chkWord(m, 1);
  endtask
  task automatic rxRun(input int n, input int eSync, input int eForce, input int eAct);
    int s, f, a;
    s = 0;
    f = 0;
    a = 0;
    for (int i = 0; i < 24 + n; i++)
    begin
      @(posedge clock);
      rxFrameStart <= 1'b1;
      @(posedge clock);
      rxFrameStart <= 1'b0;
      rxSlotValid  <= 1'b1;
      slotData     <= 8'(2 * i);
      @(negedge clock);
      s += (i >= 24 && rxMfSync === 1'b1);
      @(posedge clock);
      rxSlotValid <= 1'b0;
      @(negedge clock);
      f += (i >= 24 && slipValid === 1'b1 && slipData[0] === 1'b1);
      a += (i >= 24 && rxReinsert === 1'b1);
    end
    chkWord(s, eSync);
    chkWord(f, eForce);
    chkWord(a, eAct);
  endtask
  task automatic sig(input logic e, input logic [4:0] ch, input logic [3:0] v,
                     input logic p, input logic [3:0] x, input logic q);
    @(posedge clock);
    rxMfEnd     <= e;
    rxSignaling <= {!e, ch, v};
    @(posedge clock);
    rxMfEnd           <= 1'b0;
    rxSignaling.valid <= 1'b0;
    @(negedge clock);
    chkBit(stackPush.valid, p);
    if (p)
      chkWord({28'h0, stackPush.abcd}, {28'h0, x});
    chkBit(sigIrq, q);
  endtask
  task automatic frz(input logic x);
    repeat (2) @(negedge clock);
    chkBit(sigFreeze, x);
  endtask
  task automatic tSig;
    wr(ADDR_CTRL, 32'h1);
    wr(ADDR_STACK_EN, 32'h8);
    wr(ADDR_RX_SIGCFG, 32'h0);
    sig(0, 3, 4'h5, 1, 4'h5, 1);
    sig(0, 3, 4'h5, 0, 4'h0, 0);
    sig(0, 4, 4'hA, 0, 4'h0, 0);
    wr(ADDR_RX_SIGCFG, 32'h2);
    frz(1);
    sig(0, 3, 4'h6, 0, 4'h0, 0);
    wr(ADDR_RX_SIGCFG, 32'h6);
    frz(0);
    sig(0, 3, 4'h6, 1, 4'h6, 1);
    wr(ADDR_RX_SIGCFG, 32'h0);
    @(posedge clock);
    freezeCond <= 1'b1;
    frz(1);
    sig(0, 3, 4'h9, 0, 4'h0, 0);
    @(posedge clock);
    freezeCond <= 1'b0;
    wr(ADDR_RX_SIGCFG, 32'h10);
    sig(0, 3, 4'hF, 0, 4'h0, 0);
    frz(0);
    sig(0, 3, 4'h9, 1, 4'h9, 1);
    wr(ADDR_RX_SIGCFG, 32'h8);
    sig(0, 3, 4'h6, 0, 4'h0, 0);
    sig(0, 3, 4'h6, 1, 4'h6, 1);
    sig(0, 3, 4'h9, 0, 4'h0, 0);
    sig(1, 3, 4'h0, 0, 4'h0, 0);
    sig(0, 3, 4'hF, 0, 4'h0, 0);
    sig(0, 3, 4'hB, 1, 4'hB, 1);
    wr(ADDR_CTRL, 32'h2);
    wr(ADDR_RX_SIGCFG, 32'h40);
    sig(1, 3, 4'h0, 0, 4'h0, 1);
    sig(0, 3, 4'hC, 1, 4'hC, 0);
  endtask
  task automatic endSim;
    $display("checks %0d errors %0d", numChecks, errCount);
    if (errCount == 0 && numChecks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    #600000;
    errCount++;
    $display("[ERR] %0t watchdog expired", $time);
    endSim();
  end
  initial
  begin
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    tRegs();
    txCase(RATE_2048, 7'h00, 3'h0, 1);
    txCase(RATE_2048, 7'h05, 3'h3, 1);
    tMf();
    txCase(RATE_4096, 7'h3F, 3'h0, 1);
    txCase(RATE_4096, 7'h7F, 3'h0, 0);
    txCase(RATE_8192, 7'h7F, 3'h7, 1);
    txCase(RATE_1544, 7'h18, 3'h0, 1);
    txCase(RATE_1536, 7'h18, 3'h0, 0);
    wr(ADDR_INSERT_EN, 32'h8);
    wr(ADDR_CTRL, 32'h1);
    wr(ADDR_RX_SIGCFG, 32'h20);
    wr(ADDR_RX_FRMOFF, 32'h17);
    rxRun(48, 2, 8, 8);
    @(posedge clock);
    rxChannel <= 5'h04;
    rxRun(24, 1, 4, 0);
    @(posedge clock);
    rxChannel <= 5'h03;
    wr(ADDR_CTRL, 32'h0);
    rxRun(32, 2, 0, 2);
    @(posedge clock);
    rxMfAlign <= 1'b1;
    wr(ADDR_RX_SIGCFG, 32'h1);
    rxRun(8, 8, 0, 8);
    @(posedge clock);
    rxSlipOff <= 5'h02;
    rxRun(8, 0, 0, 0);
    tSig();
    endSim();
  end
endmodule
`default_nettype wire
